/* core/cmpc_top.sv */
// Control register, result path and edge events for one comparator.
// Assumes an external analog comparator whose output is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module cmpc_top (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rdata,
    input  wire logic        comparator_raw,
    output logic             comparator_on,
    output logic             positive_input_select,
    output logic      [1:0]  negative_input_select,
    output logic             result_output_pin,
    output logic             result_output_oe,
    output logic             irq
);
    logic        enable_reg;
    logic        enable_next;
    logic        pin_en_reg;
    logic        pin_en_next;
    logic        invert_reg;
    logic        invert_next;
    logic [1:0]  edge_reg;
    logic [1:0]  edge_next;
    logic        pos_sel_reg;
    logic        pos_sel_next;
    logic [1:0]  neg_sel_reg;
    logic [1:0]  neg_sel_next;
    logic [1:0]  status_reg;
    logic [1:0]  status_next;
    logic [1:0]  mask_reg;
    logic [1:0]  mask_next;
    logic        prev_reg;
    logic        prev_next;
    logic        pin_reg;
    logic        pin_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        raw_sync;
    logic        result;
    logic        rise_ev;
    logic        fall_ev;
    logic [1:0]  ev_set;
    logic [31:0] control_word;
    logic        hit_control;
    logic        hit_status;
    logic        hit_mask;

    cmpc_sync u_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (comparator_raw),
        .sync_out (raw_sync)
    ); // RULE15

    // A disabled comparator has no meaningful output, so it reads low.
    assign result  = enable_reg & (raw_sync ^ invert_reg); // RULE4 RULE10
    assign rise_ev = result & ~prev_reg;
    assign fall_ev = ~result & prev_reg;

    always_comb begin
        ev_set = 2'h0;
        case (edge_reg)
            cmpc_pkg::CMPC_EDGE_RISE: begin
                ev_set[cmpc_pkg::CMPC_BIT_EV_RISE] = rise_ev; // RULE7
            end
            cmpc_pkg::CMPC_EDGE_FALL: begin
                ev_set[cmpc_pkg::CMPC_BIT_EV_FALL] = fall_ev; // RULE8
            end
            cmpc_pkg::CMPC_EDGE_BOTH: ev_set = {fall_ev, rise_ev}; // RULE9
            default: ev_set = 2'h0; // RULE6
        endcase
    end

    always_comb begin
        control_word = 32'h0; // RULE13
        control_word[cmpc_pkg::CMPC_BIT_ENABLE] = enable_reg;
        control_word[cmpc_pkg::CMPC_BIT_PIN_EN] = pin_en_reg;
        control_word[cmpc_pkg::CMPC_BIT_INVERT] = invert_reg;
        control_word[cmpc_pkg::CMPC_BIT_RESULT] = result; // RULE5
        control_word[cmpc_pkg::CMPC_BIT_EDGE_LO +: 2] = edge_reg;
        control_word[cmpc_pkg::CMPC_BIT_POS_SEL] = pos_sel_reg;
        control_word[cmpc_pkg::CMPC_BIT_NEG_LO +: 2] = neg_sel_reg;
    end

    // One decode serves both the write side and the read side.
    always_comb begin
        hit_control = 1'b0;
        hit_status  = 1'b0;
        hit_mask    = 1'b0;
        if (addr == cmpc_pkg::CMPC_ADDR_CONTROL) begin
            hit_control = 1'b1;
        end else if (addr == cmpc_pkg::CMPC_ADDR_STATUS) begin
            hit_status = 1'b1;
        end else if (addr == cmpc_pkg::CMPC_ADDR_MASK) begin
            hit_mask = 1'b1;
        end
    end

    always_comb begin
        enable_next  = enable_reg;
        pin_en_next  = pin_en_reg;
        invert_next  = invert_reg;
        edge_next    = edge_reg;
        pos_sel_next = pos_sel_reg;
        neg_sel_next = neg_sel_reg;
        if (wr_en && hit_control) begin
            // Each field loads only its own bits of the word.
            enable_next  = wdata[cmpc_pkg::CMPC_BIT_ENABLE]; // RULE1 RULE2
            pin_en_next  = wdata[cmpc_pkg::CMPC_BIT_PIN_EN]; // RULE3
            invert_next  = wdata[cmpc_pkg::CMPC_BIT_INVERT]; // RULE4
            edge_next    = wdata[cmpc_pkg::CMPC_BIT_EDGE_LO +: 2]; // RULE6
            pos_sel_next = wdata[cmpc_pkg::CMPC_BIT_POS_SEL]; // RULE11
            neg_sel_next = wdata[cmpc_pkg::CMPC_BIT_NEG_LO +: 2]; // RULE12
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            enable_reg  <= cmpc_pkg::CMPC_RST_ENABLE;
            pin_en_reg  <= cmpc_pkg::CMPC_RST_PIN_EN;
            invert_reg  <= cmpc_pkg::CMPC_RST_INVERT;
            edge_reg    <= cmpc_pkg::CMPC_RST_EDGE;
            pos_sel_reg <= cmpc_pkg::CMPC_RST_POS_SEL;
            neg_sel_reg <= cmpc_pkg::CMPC_RST_NEG_SEL;
        end else begin
            enable_reg  <= enable_next;
            pin_en_reg  <= pin_en_next;
            invert_reg  <= invert_next;
            edge_reg    <= edge_next;
            pos_sel_reg <= pos_sel_next;
            neg_sel_reg <= neg_sel_next;
        end
    end

    always_comb begin
        status_next = status_reg;
        mask_next   = mask_reg;
        prev_next   = result;
        if (wr_en && hit_status) begin
            status_next = status_reg & ~wdata[1:0];
        end else if (wr_en && hit_mask) begin
            mask_next = wdata[1:0];
        end
        // Set wins over a same-cycle write-one clear, so no edge is lost.
        status_next = status_next | ev_set;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            status_reg <= cmpc_pkg::CMPC_RST_EVENTS;
            mask_reg   <= cmpc_pkg::CMPC_RST_EVENTS;
            prev_reg   <= 1'b0;
        end else begin
            status_reg <= status_next;
            mask_reg   <= mask_next;
            prev_reg   <= prev_next;
        end
    end

    // Registering the pin keeps decode and sync glitches off the pad.
    always_comb begin
        pin_next = result;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_reg <= 1'b0;
        end else begin
            pin_reg <= pin_next;
        end
    end

    // Read data stand for one cycle only; unmapped reads return zero.
    always_comb begin
        rdata_next = 32'h0; // RULE13
        if (rd_en) begin
            if (hit_control) begin
                rdata_next = control_word;
            end else if (hit_status) begin
                rdata_next = {30'h0, status_reg};
            end else if (hit_mask) begin
                rdata_next = {30'h0, mask_reg};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_reg <= 32'h0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata                 = rdata_reg;
    assign comparator_on         = enable_reg; // RULE1 RULE2
    assign positive_input_select = pos_sel_reg; // RULE11
    assign negative_input_select = neg_sel_reg; // RULE12
    assign result_output_oe      = pin_en_reg; // RULE3
    assign result_output_pin     = pin_en_reg & pin_reg; // RULE3
    assign irq                   = |(status_reg & mask_reg);

    a_rise_event: assert property (@(posedge clk) disable iff (reset) // RULE7
        (edge_reg == cmpc_pkg::CMPC_EDGE_RISE && rise_ev && !wr_en)
        |=> status_reg[cmpc_pkg::CMPC_BIT_EV_RISE])
        else $error("rising edge not recorded");
    a_fall_event: assert property (@(posedge clk) disable iff (reset) // RULE8
        (edge_reg == cmpc_pkg::CMPC_EDGE_FALL && fall_ev && !wr_en)
        |=> status_reg[cmpc_pkg::CMPC_BIT_EV_FALL])
        else $error("falling edge not recorded");
    a_both_event: assert property (@(posedge clk) disable iff (reset) // RULE9
        (edge_reg == cmpc_pkg::CMPC_EDGE_BOTH && (rise_ev || fall_ev))
        |=> (status_reg != 2'h0))
        else $error("edge not recorded in both mode");
    a_none_quiet: assert property (@(posedge clk) disable iff (reset) // RULE6
        (edge_reg == cmpc_pkg::CMPC_EDGE_NONE && status_reg == 2'h0)
        |=> (status_reg == 2'h0))
        else $error("event raised while disabled");
    a_result_read: assert property (@(posedge clk) disable iff (reset) // RULE5
        (rd_en && addr == cmpc_pkg::CMPC_ADDR_CONTROL)
        |=> rdata[cmpc_pkg::CMPC_BIT_RESULT] == $past(result))
        else $error("result bit mismatch");
    a_invert_path: assert property (@(posedge clk) disable iff (reset) // RULE4
        enable_reg |-> (result == ($past(comparator_raw, 2) ^ invert_reg)))
        else $error("inversion not applied");
    a_sync_delay: assert property (@(posedge clk) disable iff (reset) // RULE15
        ##2 (raw_sync == $past(comparator_raw, 2)))
        else $error("synchroniser latency wrong");
    a_upper_zero: assert property (@(posedge clk) disable iff (reset) // RULE13
        rd_en |=> (rdata[31:16] == 16'h0 && rdata[12:9] == 4'h0
                   && rdata[5] == 1'b0 && rdata[3:2] == 2'h0))
        else $error("unused bits not zero");
    a_pin_gate: assert property (@(posedge clk) disable iff (reset) // RULE3
        !pin_en_reg |-> !result_output_pin)
        else $error("pin driven while disabled");
    a_enable_keep: assert property (@(posedge clk) disable iff (reset) // RULE1
        (wr_en && addr == cmpc_pkg::CMPC_ADDR_CONTROL)
        |=> (enable_reg == $past(wdata[cmpc_pkg::CMPC_BIT_ENABLE])
             && neg_sel_reg == $past(wdata[1:0])))
        else $error("control write wrong");

    // Mode exclusivity: a selected edge must never record the other one.
    a_rise_only: assert property (@(posedge clk) disable iff (reset) // RULE7
        (edge_reg == cmpc_pkg::CMPC_EDGE_RISE && !wr_en)
        |=> (status_reg[cmpc_pkg::CMPC_BIT_EV_FALL]
             == $past(status_reg[cmpc_pkg::CMPC_BIT_EV_FALL])))
        else $error("falling edge recorded in rising mode");
    a_fall_only: assert property (@(posedge clk) disable iff (reset) // RULE8
        (edge_reg == cmpc_pkg::CMPC_EDGE_FALL && !wr_en)
        |=> (status_reg[cmpc_pkg::CMPC_BIT_EV_RISE]
             == $past(status_reg[cmpc_pkg::CMPC_BIT_EV_RISE])))
        else $error("rising edge recorded in falling mode");
    a_none_hold: assert property (@(posedge clk) disable iff (reset) // RULE6
        (edge_reg == cmpc_pkg::CMPC_EDGE_NONE && !wr_en)
        |=> (status_reg == $past(status_reg)))
        else $error("status changed with events off");
    a_ctl_stable: assert property (@(posedge clk) disable iff (reset) // RULE1
        !(wr_en && hit_control)
        |=> (control_word[15:13] == $past(control_word[15:13])
             && control_word[7:0] == $past(control_word[7:0])))
        else $error("control field changed without a write");
    a_pos_write: assert property (@(posedge clk) disable iff (reset) // RULE11
        (wr_en && hit_control) |=> (positive_input_select
             == $past(wdata[cmpc_pkg::CMPC_BIT_POS_SEL])))
        else $error("positive input select not loaded");
    a_pin_follow: assert property (@(posedge clk) disable iff (reset) // RULE3
        pin_en_reg |-> (result_output_pin == $past(result)))
        else $error("pin does not carry the result");
    a_unmapped: assert property (@(posedge clk) disable iff (reset) // RULE13
        (rd_en && !hit_control && !hit_status && !hit_mask)
        |=> (rdata == 32'h0))
        else $error("unmapped read not zero");
    a_set_wins: assert property (@(posedge clk) disable iff (reset) // RULE6
        (ev_set != 2'h0)
        |=> ((status_reg & $past(ev_set)) == $past(ev_set)))
        else $error("edge event lost");
    a_inv_edge: assert property (@(posedge clk) disable iff (reset) // RULE10
        (invert_reg && $past(invert_reg) && enable_reg && $past(enable_reg)
         && $rose(raw_sync)) |-> fall_ev)
        else $error("inverted rise not seen as fall");
    a_plain_edge: assert property (@(posedge clk) disable iff (reset) // RULE15
        (!invert_reg && !$past(invert_reg) && enable_reg && $past(enable_reg)
         && $rose(raw_sync)) |-> rise_ev)
        else $error("synchronised rise not detected");

    // Cover points for the main scenarios of the bench.
    c_rise: cover property (@(posedge clk) disable iff (reset)
        edge_reg == cmpc_pkg::CMPC_EDGE_RISE && rise_ev);
    c_irq: cover property (@(posedge clk) disable iff (reset) irq);
    c_inverted_fall: cover property (@(posedge clk) disable iff (reset)
        invert_reg && fall_ev);
    c_fall: cover property (@(posedge clk) disable iff (reset)
        edge_reg == cmpc_pkg::CMPC_EDGE_FALL && fall_ev);
    c_both: cover property (@(posedge clk) disable iff (reset)
        edge_reg == cmpc_pkg::CMPC_EDGE_BOTH && (rise_ev || fall_ev));
endmodule // cmpc_top
`default_nettype wire

/* core/cmpc_pkg.sv */
// Package for the comparator control block: offsets, fields, resets.
// Assumes a plain register port with one-cycle read latency.
// Functional notes
// RULE1: Enable set powers comparator, other fields kept.
// RULE2: Enable clear powers down, other fields kept.
// RULE3: Pin enable drives result onto output pin.
// RULE4: Invert bit inverts presented comparator result.
// RULE5: Read-only result bit mirrors comparator output.
// RULE6: Edge select 00 suppresses all events.
// RULE7: Code 01 events on rising edge only.
// RULE8: Code 10 events on falling edge only.
// RULE9: Code 11 events on both edges.
// RULE10: Inversion also feeds the edge detector.
// RULE11: Positive select: reference if 1, pin A if 0.
// RULE12: Negative select: B, C, D, band-gap.
// RULE13: Unused control bits read zero, ignore writes.
// RULE14: Software avoids access right after disabling.
// RULE15: Comparator output synchronised before use.
`default_nettype none
package cmpc_pkg;
    localparam logic [3:0]  CMPC_ADDR_CONTROL = 4'h0;
    localparam logic [3:0]  CMPC_ADDR_STATUS  = 4'h4;
    localparam logic [3:0]  CMPC_ADDR_MASK    = 4'h8;
    localparam int          CMPC_BIT_ENABLE   = 15;
    localparam int          CMPC_BIT_PIN_EN   = 14;
    localparam int          CMPC_BIT_INVERT   = 13;
    localparam int          CMPC_BIT_RESULT   = 8;
    localparam int          CMPC_BIT_EDGE_LO  = 6;
    localparam int          CMPC_BIT_POS_SEL  = 4;
    localparam int          CMPC_BIT_NEG_LO   = 0;
    localparam int          CMPC_BIT_EV_RISE  = 0;
    localparam int          CMPC_BIT_EV_FALL  = 1;
    localparam logic        CMPC_RST_ENABLE   = 1'b0;
    localparam logic        CMPC_RST_PIN_EN   = 1'b0;
    localparam logic        CMPC_RST_INVERT   = 1'b0;
    localparam logic [1:0]  CMPC_RST_EDGE     = 2'h3;
    localparam logic        CMPC_RST_POS_SEL  = 1'b0;
    localparam logic [1:0]  CMPC_RST_NEG_SEL  = 2'h3;
    localparam logic [1:0]  CMPC_RST_EVENTS   = 2'h0;
    localparam logic [1:0]  CMPC_EDGE_NONE    = 2'h0;
    localparam logic [1:0]  CMPC_EDGE_RISE    = 2'h1;
    localparam logic [1:0]  CMPC_EDGE_FALL    = 2'h2;
    localparam logic [1:0]  CMPC_EDGE_BOTH    = 2'h3;
endpackage
`default_nettype wire

/* core/cmpc_sync.sv */
// Two-stage synchroniser for one asynchronous level.
// Assumes the level may change at any time relative to clk.
`timescale 1ns/1ps
`default_nettype none
module cmpc_sync (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic async_in,
    output logic      sync_out
);
    logic stage1_reg;
    logic stage2_reg;
    logic stage1_next;
    logic stage2_next;

    always_comb begin
        stage1_next = async_in;
        stage2_next = stage1_reg;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign sync_out = stage2_reg;
endmodule // cmpc_sync
`default_nettype wire

/* dv/cmpc_comp_model.sv */
// Behavioural analog comparator core with its input multiplexers.
// Assumes the bench hands pin voltages over as unsigned level codes.
`timescale 1ns/1ps
`default_nettype none
module cmpc_comp_model #(
    parameter logic [7:0] LADDER_LVL  = 8'h80,
    parameter logic [7:0] BANDGAP_LVL = 8'h60
) (
    input  wire logic       power_on,
    input  wire logic       pos_sel,
    input  wire logic [1:0] neg_sel,
    input  wire logic [7:0] pin_a,
    input  wire logic [7:0] pin_b,
    input  wire logic [7:0] pin_c,
    input  wire logic [7:0] pin_d,
    output logic            out_raw
);
    logic [7:0] vp;
    logic [7:0] vn;
    always_comb begin
        vp = pos_sel ? LADDER_LVL : pin_a;
        case (neg_sel)
            2'h0: vn = pin_b;
            2'h1: vn = pin_c;
            2'h2: vn = pin_d;
            default: vn = BANDGAP_LVL;
        endcase
    end
    // The delay keeps the output off the clock edge, as a real core would.
    assign #3 out_raw = power_on & (vp > vn);
endmodule // cmpc_comp_model
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the comparator control block.
// Assumes the behavioural core model closes the loop to comparator_raw.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [7:0] LAD = 8'h80;
    localparam logic [7:0] BG  = 8'h60;
    logic        clk   = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  addr  = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [7:0]  va    = 8'h0;
    logic [7:0]  vb    = 8'h0;
    logic [7:0]  vc    = 8'h0;
    logic [7:0]  vd    = 8'h0;
    logic [31:0] rdata;
    logic        raw, on, psel, pin, oe, irq;
    logic [1:0]  nsel;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cycles    = 0;
    always #4 clk = ~clk;
    cmpc_top dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .comparator_raw(raw),
        .comparator_on(on), .positive_input_select(psel),
        .negative_input_select(nsel), .result_output_pin(pin),
        .result_output_oe(oe), .irq(irq));
    cmpc_comp_model #(.LADDER_LVL(LAD), .BANDGAP_LVL(BG)) core_u (
        .power_on(on), .pos_sel(psel), .neg_sel(nsel), .pin_a(va),
        .pin_b(vb), .pin_c(vc), .pin_d(vd), .out_raw(raw));
    function automatic logic res_exp(logic [31:0] c);
        logic [7:0] p;
        logic [7:0] n;
        p = c[4] ? LAD : va;
        n = c[1] ? (c[0] ? BG : vd) : (c[0] ? vc : vb);
        return c[15] & ((p > n) ^ c[13]);
    endfunction
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd(logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic summarize();
        $display("errors %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        logic [31:0] d, c, ctl, st;
        logic [1:0]  m;
        void'($urandom(2113));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd(4'h0, d);
        chk("ctl_reset", d, 32'h000000C3);
        chk("out_reset", 32'({on, oe, pin, irq, nsel}), 32'h3);
        wr(4'hC, 32'hFFFFFFFF);
        rd(4'hC, d);
        chk("unmapped", d, 32'h0);
        for (int i = 0; i < 12; i++) begin
            c = $urandom();
            c[15] = 1'(i);
            va <= 8'($urandom());
            vb <= 8'($urandom());
            vc <= 8'($urandom());
            vd <= 8'($urandom());
            wr(4'h0, c);
            // Enable may just have been cleared: leave the bus quiet.
            repeat (6) @(posedge clk);
            ctl = c & 32'h0000E0D3;
            rd(4'h0, d);
            chk("ctl", d, ctl | (32'(res_exp(ctl)) << 8));
            chk("sel", 32'({on, psel, nsel, oe}),
                32'({ctl[15], ctl[4], ctl[1:0], ctl[14]}));
            chk("pin", 32'(pin), 32'(ctl[14] & res_exp(ctl)));
        end
        for (int k = 0; k < 8; k++) begin
            c = {16'h0, 2'h3, k[2], 5'h0, k[1:0], 6'h0};
            m = 2'($urandom());
            va <= 8'h10;
            vb <= 8'h40;
            wr(4'h0, c);
            wr(4'h8, 32'(m));
            repeat (6) @(posedge clk);
            wr(4'h4, 32'h3);
            va <= 8'h70;
            repeat (6) @(posedge clk);
            st = k[2] ? {30'h0, k[1], 1'b0} : {31'h0, k[0]};
            rd(4'h4, d);
            chk("rise_ev", d, st);
            chk("irq", 32'(irq), 32'(|(st[1:0] & m)));
            wr(4'h4, 32'h3);
            va <= 8'h10;
            repeat (6) @(posedge clk);
            st = k[2] ? {31'h0, k[0]} : {30'h0, k[1], 1'b0};
            rd(4'h4, d);
            chk("fall_ev", d, st);
        end
        summarize();
    end
endmodule // tb_top
`default_nettype wire
